// [common/dms_pkg.sv]
package dms_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_PSHIFT = 8'h08;
  localparam logic [7:0] OFF_RPT = 8'h0c;
  localparam logic [7:0] OFF_ACC = 8'h10;
  localparam logic [7:0] OFF_PROD = 8'h14;
  localparam logic [7:0] OFF_MULT = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_ST = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h28;

  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_KIND_LSB = 4;
  localparam int CTRL_RPT = 7;
  localparam int CTRL_SH_LSB = 8;

  // Status register fields
  localparam int STAT_N = 0;
  localparam int STAT_Z = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_CNT_LSB = 16;

  // Event bits
  localparam int EV_DONE = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_W = 2;

  // Accumulator shift bounds for the high-word store
  localparam logic [3:0] SH_MIN = 4'h1;
  localparam logic [3:0] SH_MAX = 4'h8;
  localparam logic [4:0] HALF_W = 5'h10;

  // Long operand word offset of the delay-line destination
  localparam int DLY_OFS = 2;

  typedef enum logic [2:0] {
    OP_DELAY_LINE_MOVE,
    OP_STORE_HIGH_ACC,
    OP_STORE_HIGH_PROD,
    OP_LOAD_ACC_MEM,
    OP_LOAD_ACC_PROD
  } dms_op_t;

  typedef enum logic [2:0] {
    KIND_MEMORY,
    KIND_UPPER_HALF_SUM,
    KIND_LOWER_HALF_SUM,
    KIND_AUX_POINTER_REGISTER,
    KIND_ACC,
    KIND_PRODUCT,
    KIND_MULTIPLICAND_REGISTER
  } dms_kind_t;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : dms_pkg

// [rtl/dms_exec.sv]
`timescale 1ns/1ps
module dms_exec #(
  parameter int MEM_AW = 16,
  parameter int RPT_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data memory, 16-bit words
  output logic mem_req,
  output logic mem_we,
  output logic [MEM_AW-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // Interrupt
  output logic irq
);
  import dms_pkg::*;

  typedef enum {ST_IDLE, ST_RD_LO, ST_RD_HI, ST_WR_LO, ST_WR_HI, ST_STORE} dms_state_t;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFF_CTRL || a == OFF_ADDR || a == OFF_PSHIFT || a == OFF_RPT ||
           a == OFF_ACC || a == OFF_PROD || a == OFF_MULT || a == OFF_STAT ||
           a == OFF_IRQ_ST || a == OFF_IRQ_EN || a == OFF_IRQ_CLR;
  endfunction : is_mapped

  function automatic logic [31:0] shift_prod(input logic [31:0] p, input logic [3:0] mode);
    logic signed [31:0] sp;
    sp = signed'(p);
    if (!mode[3]) begin
      return p << mode;
    end
    // Magnitude of a negative mode is sixteen minus its raw code
    return 32'(sp >>> (HALF_W - 5'(mode)));
  endfunction : shift_prod

  dms_state_t state, next_state;
  dms_op_t op, next_op;
  dms_kind_t kind, next_kind;
  logic [3:0] shamt, next_shamt;
  logic [MEM_AW-1:0] opnd_addr, next_opnd_addr;
  logic [3:0] product_shift_mode, next_product_shift_mode;
  logic [RPT_W-1:0] repeat_counter, next_repeat_counter;
  logic [RPT_W-1:0] iter, next_iter;
  logic [31:0] acc, next_acc;
  logic [31:0] prod, next_prod;
  logic [31:0] multiplicand_register, next_multiplicand_register;
  logic [15:0] lo_word, next_lo_word;
  logic flag_n, next_flag_n;
  logic flag_z, next_flag_z;
  logic [EV_W-1:0] ev_st, next_ev_st;
  logic [EV_W-1:0] ev_en, next_ev_en;
  logic [31:0] next_prdata;
  logic next_mem_we;
  logic [MEM_AW-1:0] next_mem_addr;
  logic [15:0] next_mem_wdata;

  logic wr_acc, rd_setup;
  logic [EV_W-1:0] ev_set, ev_clr;
  logic [31:0] prod_sh;
  logic [15:0] acc_high;
  logic [31:0] acc_shr;
  logic [15:0] store_val;

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign mem_req = state != ST_IDLE && !(state == ST_STORE && kind != KIND_MEMORY);
  assign irq = |(ev_st & ev_en);

  assign prod_sh = shift_prod(prod, product_shift_mode);
  assign acc_shr = acc >> (HALF_W - 5'(shamt));
  assign acc_high = acc_shr[15:0];
  assign store_val = (op == OP_STORE_HIGH_ACC) ? acc_high : prod_sh[31:16];

  always_comb begin
    logic [31:0] ld;
    logic [15:0] half;
    logic last;
    ld = {mem_rdata, lo_word};
    half = 16'h0000;
    last = iter == '0;
    next_state = state;
    next_op = op;
    next_kind = kind;
    next_shamt = shamt;
    next_opnd_addr = opnd_addr;
    next_product_shift_mode = product_shift_mode;
    next_repeat_counter = repeat_counter;
    next_iter = iter;
    next_acc = acc;
    next_prod = prod;
    next_multiplicand_register = multiplicand_register;
    next_lo_word = lo_word;
    next_flag_n = flag_n;
    next_flag_z = flag_z;
    next_ev_en = ev_en;
    next_mem_we = mem_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    ev_set = '0;
    ev_clr = '0;
    next_prdata = prdata;

    if (rd_setup) begin
      unique case (paddr)
        OFF_ADDR: next_prdata = 32'(opnd_addr);
        OFF_PSHIFT: next_prdata = 32'(product_shift_mode);
        OFF_RPT: next_prdata = 32'(repeat_counter);
        OFF_ACC: next_prdata = acc;
        OFF_PROD: next_prdata = prod;
        OFF_MULT: next_prdata = multiplicand_register;
        OFF_STAT: next_prdata = {16'(iter), 13'h0, state != ST_IDLE, flag_z, flag_n};
        OFF_IRQ_ST: next_prdata = 32'(ev_st);
        OFF_IRQ_EN: next_prdata = 32'(ev_en);
        default: next_prdata = RST_WORD;
      endcase
    end

    // Operand registers are only writable while idle so a running op sees stable inputs
    if (wr_acc && state == ST_IDLE) begin
      unique case (paddr)
        OFF_ADDR: next_opnd_addr = pwdata[MEM_AW-1:0];
        OFF_PSHIFT: next_product_shift_mode = pwdata[3:0];
        OFF_RPT: next_repeat_counter = pwdata[RPT_W-1:0];
        OFF_ACC: next_acc = pwdata;
        OFF_PROD: next_prod = pwdata;
        OFF_MULT: next_multiplicand_register = pwdata;
        default: ;
      endcase
    end
    if (wr_acc && paddr == OFF_IRQ_EN) begin
      next_ev_en = pwdata[EV_W-1:0];
    end
    if (wr_acc && paddr == OFF_IRQ_CLR) begin
      ev_clr = pwdata[EV_W-1:0];
    end

    unique case (state)
      ST_IDLE: begin
        if (wr_acc && paddr == OFF_CTRL && pwdata[CTRL_START]) begin
          next_op = dms_op_t'(pwdata[CTRL_OP_LSB +: 3]);
          next_kind = dms_kind_t'(pwdata[CTRL_KIND_LSB +: 3]);
          next_shamt = pwdata[CTRL_SH_LSB +: 4];
          next_iter = '0;
          if (pwdata[CTRL_RPT]) begin
            if (next_op == OP_STORE_HIGH_ACC || next_op == OP_STORE_HIGH_PROD) begin
              next_iter = repeat_counter;
            end
            next_repeat_counter = '0;
          end
          next_mem_we = 1'b0;
          next_mem_addr = {opnd_addr[MEM_AW-1:1], 1'b0};
          if (next_op == OP_DELAY_LINE_MOVE && next_kind != KIND_MEMORY) begin
            ev_set[EV_TRAP] = 1'b1;
            next_iter = '0;
          end else if ((next_op == OP_STORE_HIGH_ACC || next_op == OP_STORE_HIGH_PROD) &&
                       next_kind > KIND_LOWER_HALF_SUM) begin
            ev_set[EV_TRAP] = 1'b1;
            next_iter = '0;
          end else if (next_op == OP_STORE_HIGH_ACC &&
                       (next_shamt < SH_MIN || next_shamt > SH_MAX)) begin
            ev_set[EV_TRAP] = 1'b1;
            next_iter = '0;
          end else if (next_op == OP_LOAD_ACC_MEM && next_kind != KIND_MEMORY) begin
            ev_set[EV_TRAP] = 1'b1;
          end else if (next_op == OP_LOAD_ACC_PROD) begin
            next_acc = prod_sh;
            next_flag_n = prod_sh[31];
            next_flag_z = prod_sh == '0;
            ev_set[EV_DONE] = 1'b1;
          end else if (next_op == OP_DELAY_LINE_MOVE || next_op == OP_LOAD_ACC_MEM) begin
            next_state = ST_RD_LO;
          end else if (next_op <= OP_STORE_HIGH_PROD) begin
            next_state = ST_STORE;
            next_mem_we = 1'b1;
            next_mem_addr = opnd_addr;
            // Write data must already stand when the request rises
            next_mem_wdata = (next_op == OP_STORE_HIGH_ACC) ?
                             16'(acc >> (HALF_W - 5'(next_shamt))) : prod_sh[31:16];
          end else begin
            ev_set[EV_TRAP] = 1'b1;
          end
        end
      end
      ST_RD_LO: begin
        if (mem_ack) begin
          next_lo_word = mem_rdata;
          next_mem_addr = mem_addr + MEM_AW'(1);
          next_state = ST_RD_HI;
        end
      end
      ST_RD_HI: begin
        if (mem_ack) begin
          if (op == OP_DELAY_LINE_MOVE) begin
            next_multiplicand_register = ld;
            next_mem_we = 1'b1;
            next_mem_addr = mem_addr + MEM_AW'(DLY_OFS - 1);
            next_mem_wdata = ld[15:0];
            next_state = ST_WR_LO;
          end else begin
            next_acc = ld;
            next_flag_n = ld[31];
            next_flag_z = ld == '0;
            ev_set[EV_DONE] = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_WR_LO: begin
        if (mem_ack) begin
          next_mem_addr = mem_addr + MEM_AW'(1);
          next_mem_wdata = multiplicand_register[31:16];
          next_state = ST_WR_HI;
        end
      end
      ST_WR_HI: begin
        if (mem_ack) begin
          next_mem_we = 1'b0;
          ev_set[EV_DONE] = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_STORE: begin
        next_mem_wdata = store_val;
        if (kind != KIND_MEMORY || mem_ack) begin
          if (kind == KIND_UPPER_HALF_SUM) begin
            next_acc[31:16] = store_val;
            half = store_val;
          end else if (kind == KIND_LOWER_HALF_SUM) begin
            next_acc[15:0] = store_val;
            half = store_val;
          end
          // Flags only follow the half target, and only on the last pass
          if (kind != KIND_MEMORY && last) begin
            next_flag_n = half[15];
            next_flag_z = half == 16'h0000;
          end
          if (last) begin
            next_mem_we = 1'b0;
            ev_set[EV_DONE] = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_iter = iter - RPT_W'(1);
            next_mem_addr = mem_addr + MEM_AW'(1);
          end
        end
      end
    endcase

    // A new event wins over a clear in the same cycle
    next_ev_st = (ev_st & ~ev_clr) | ev_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op <= OP_DELAY_LINE_MOVE;
      kind <= KIND_MEMORY;
      shamt <= '0;
      opnd_addr <= '0;
      product_shift_mode <= '0;
      repeat_counter <= '0;
      iter <= '0;
      acc <= RST_WORD;
      prod <= RST_WORD;
      multiplicand_register <= RST_WORD;
      lo_word <= '0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      ev_st <= '0;
      ev_en <= '0;
      prdata <= RST_WORD;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      kind <= next_kind;
      shamt <= next_shamt;
      opnd_addr <= next_opnd_addr;
      product_shift_mode <= next_product_shift_mode;
      repeat_counter <= next_repeat_counter;
      iter <= next_iter;
      acc <= next_acc;
      prod <= next_prod;
      multiplicand_register <= next_multiplicand_register;
      lo_word <= next_lo_word;
      flag_n <= next_flag_n;
      flag_z <= next_flag_z;
      ev_st <= next_ev_st;
      ev_en <= next_ev_en;
      prdata <= next_prdata;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

endmodule : dms_exec

// [verification/dms_exec_asserts.sv]
`timescale 1ns/1ps
module dms_exec_asserts #(
  parameter int MEM_AW = 16
) (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  import dms_pkg::*;
  logic [15:0] lo_w;
  logic [15:0] hi_w;
  logic lo_seen;
  logic dly;
  wire rd_ack = mem_req && mem_ack && !mem_we;
  wire wr_ack = mem_req && mem_ack && mem_we;
  // Delay flag drops on any idle cycle, so a plain long load arms it for one cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_w <= 16'h0;
      hi_w <= 16'h0;
      lo_seen <= 1'b0;
      dly <= 1'b0;
    end else begin
      if (rd_ack && !mem_addr[0]) lo_w <= mem_rdata;
      if (rd_ack && mem_addr[0]) hi_w <= mem_rdata;
      if (rd_ack) lo_seen <= !mem_addr[0];
      if (rd_ack && mem_addr[0]) dly <= 1'b1;
      else if (!mem_req || (wr_ack && mem_addr[0])) dly <= 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_lo_rd;
    rd_ack && !mem_addr[0];
  endsequence
  sequence s_hi_rd;
    rd_ack && mem_addr[0];
  endsequence
  a_lo_then_hi: assert property (s_lo_rd |=>
    mem_req && !mem_we && mem_addr == $past(mem_addr) + 1'b1) else $error("no high read");
  a_dly_wr_lo: assert property (s_hi_rd ##1 (mem_req && mem_we) |->
    mem_addr == $past(mem_addr) + 1'b1 && mem_wdata == lo_w) else $error("bad delay low");
  a_dly_wr_hi: assert property (dly && wr_ack && !mem_addr[0] |=>
    mem_req && mem_we && mem_addr == $past(mem_addr) + 1'b1 && mem_wdata == hi_w)
    else $error("bad delay high");
  a_req_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("request dropped");
  a_hi_after_lo: assert property (mem_req && !mem_we && mem_addr[0] |-> lo_seen)
    else $error("high read first");
  a_rd_even: assert property ($rose(mem_req) && !mem_we |-> !mem_addr[0])
    else $error("odd long read");
  a_unmapped_err: assert property (psel && penable && paddr > OFF_IRQ_CLR |-> pslverr)
    else $error("no slave error");
  a_mapped_ok: assert property (psel && penable && paddr <= OFF_IRQ_CLR && paddr[1:0] == 2'h0
    |-> pready && !pslverr) else $error("mapped access failed");
endmodule : dms_exec_asserts

bind dms_exec dms_exec_asserts #(.MEM_AW(MEM_AW)) u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);

// [verification/dms_mem_model.sv]
`timescale 1ns/1ps
module dms_mem_model (
  // Clock, reset and pacing
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] mem [0:255];
  int wait_n;
  // Read lines toggle between acks so stale data never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0;
      wait_n <= 0;
    end else if (mem_req && !mem_ack && wait_n == 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[7:0]];
      wait_n <= slow ? int'($urandom % 4) : 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && wait_n > 0) wait_n <= wait_n - 1;
    end
  end
  always @(posedge pclk) begin
    if (mem_req && mem_ack && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
  end
endmodule : dms_mem_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
  import dms_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic mem_req, mem_we, mem_ack, irq, slow, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, x, e;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, h;
  int failures, checks_done, ien, a, s, k, j, m;
  dms_exec DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .irq);
  dms_mem_model u_mem (.pclk, .presetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack);
  always #4 pclk = ~pclk;
  task give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Starts one edge late so release and next setup never share a time step
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic flg(input logic n, input logic z);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd & 32'h3, {30'h0, z, n});
  endtask : flg
  task automatic run(input logic [31:0] ctl, input logic [1:0] ev);
    int n;
    apb(1'b1, OFF_CTRL, ctl);
    for (n = 0; n < 50; n++) begin
      apb(1'b0, OFF_STAT, 32'h0);
      if (rd[STAT_BUSY] === 1'b0) break;
    end
    rdc(OFF_IRQ_ST, {30'h0, ev});
    chk({31'h0, irq}, {31'h0, |(ev & ien[1:0])});
    apb(1'b1, OFF_IRQ_CLR, 32'h3);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask : run
  function automatic logic [31:0] psh(input logic [31:0] p, input int sh);
    if (sh >= 0) return p << sh;
    return $signed(p) >>> (-sh);
  endfunction : psh
  initial begin
    #300000;
    failures++;
    give_verdict();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    slow = 1'b0;
    void'($urandom(24));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, OFF_IRQ_EN, 32'h3);
    ien = 3;
    // Long loads behind a repeat prefix, odd address given
    for (k = 0; k < 3; k++) begin
      v = k == 0 ? $urandom : (k == 1 ? 32'h0 : ($urandom | 32'h8000_0000));
      a = 16 + 4 * k;
      u_mem.mem[a] = v[15:0];
      u_mem.mem[a+1] = v[31:16];
      slow <= k[0];
      apb(1'b1, OFF_RPT, 32'h3);
      apb(1'b1, OFF_ADDR, 32'(a + 1));
      run(32'h87, 2'h1);
      rdc(OFF_ACC, v);
      rdc(OFF_RPT, 32'h0);
      flg(v[31], v == 0);
    end
    v = $urandom;
    u_mem.mem[64] = v[15:0];
    u_mem.mem[65] = v[31:16];
    apb(1'b1, OFF_ADDR, 32'd64);
    run(32'h1, 2'h1);
    rdc(OFF_MULT, v);
    chk({u_mem.mem[67], u_mem.mem[66]}, v);
    apb(1'b1, OFF_IRQ_EN, 32'h1);
    ien = 1;
    for (k = 3; k < 7; k++) begin
      run(32'(1 + (k << 4)), 2'h2);
      rdc(OFF_MULT, v);
    end
    apb(1'b1, OFF_IRQ_EN, 32'h3);
    ien = 3;
    for (k = 0; k < 3; k++) begin
      x = $urandom;
      s = 1 + $urandom % 8;
      a = 128 + 8 * k;
      apb(1'b1, OFF_ACC, x);
      apb(1'b1, OFF_RPT, 32'h2);
      apb(1'b1, OFF_ADDR, 32'(a));
      run(32'(8'h83 + (k << 4) + (s << 8)), 2'h1);
      e = x;
      for (j = 0; j < 3; j++) begin
        h = 16'(e >> (16 - s));
        if (k == 0) chk(u_mem.mem[a+j], h);
        if (k == 1) e[31:16] = h;
        if (k == 2) e[15:0] = h;
      end
      rdc(OFF_ACC, e);
      if (k != 0) flg(h[15], h == 0);
    end
    for (m = -8; m < 8; m++) begin
      x = m == 0 ? 32'h0 : $urandom;
      v = $urandom;
      apb(1'b1, OFF_PROD, x);
      apb(1'b1, OFF_PSHIFT, 32'(m & 15));
      apb(1'b1, OFF_ACC, v);
      run(32'h15, 2'h1);
      e = psh(x, m);
      rdc(OFF_ACC, {e[31:16], v[15:0]});
      flg(e[31], e[31:16] == 0);
      run(32'h9, 2'h1);
      rdc(OFF_ACC, e);
      flg(e[31], e == 0);
      rdc(OFF_PROD, x);
    end
    rdc(8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    give_verdict();
  end
endmodule : tb
